// [bench/ipsc_core_assertions.sv]
// Checker for ipsc_core: fixed read-back bits and request forwarding.
// Assumes hready is the slave's own hreadyout.
module ipsc_core_assertions (
   input wire logic                clk,
   input wire logic                rst_b,
   input wire logic                hsel,
   input wire logic [31:0]         haddr,
   input wire logic [1:0]          htrans,
   input wire logic                hwrite,
   input wire logic                hready,
   input wire logic [31:0]         hrdata,
   input wire logic [7:0]          expansion_request_inputs_b,
   input wire logic [11:0]         internal_requests,
   input wire logic [2:0]          cpu_mask_level,
   input wire logic                cpu_int_mask,
   input wire ipsc_pkg::ipsc_req_t cpu_req
);
   timeunit 1ns / 1ps;
   logic [7:0]  exp_q;
   logic [11:0] int_q;
   logic [3:0]  msk_q;
   wire         rd = hsel && hready && htrans[1] && !hwrite;
   wire  [4:0]  src = cpu_req.source;
   wire         v = cpu_req.valid;
   // Inputs as the request stage saw them
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         exp_q <= 8'hff;
         int_q <= 12'h000;
         msk_q <= 4'hf;
      end else begin
         exp_q <= expansion_request_inputs_b;
         int_q <= internal_requests;
         msk_q <= {cpu_int_mask, cpu_mask_level};
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   prio_zero_bits_a: assert property (
      rd && haddr <= 32'h20 |=> hrdata[31:8] == 0 && !hrdata[7] && !hrdata[3])
      else $error("priority reserved bit set");
   prio_d_low_a: assert property (rd && haddr == 32'hc |=> hrdata[2:0] == 3'h7)
      else $error("priority D low field not ones");
   enable_width_a: assert property (rd && haddr == 32'h24 |=> hrdata[31:8] == 0)
      else $error("enable upper bits set");
   sense_width_a: assert property (rd && haddr == 32'h28 |=> hrdata[31:16] == 0)
      else $error("sense upper bits set");
   mask_level_a: assert property (v |-> !msk_q[3] || cpu_req.level > msk_q[2:0])
      else $error("request at or below mask level");
   source_map_a: assert property (v |-> src <= 5'd16 || (src >= 5'd20 && src <= 5'd27))
      else $error("request from unmapped source");
   internal_src_a: assert property (v && src >= 5'd8 && src <= 5'd16 |-> int_q[src - 5'd8])
      else $error("internal request without source");
   expansion_src_a: assert property (v && src >= 5'd20 |-> !exp_q[src - 5'd20])
      else $error("expansion request while input high");
   cover property (v && src < 5'd8);
   cover property (v && src >= 5'd20);
   cover property (rd && haddr == 32'hc);
endmodule // ipsc_core_assertions

// [bench/ipsc_cpu_model.sv]
// CPU and transfer controller stand-in: acknowledges forwarded pin requests.
// Assumes the bench enables it and sets its answer delay and transfer pulses.
module ipsc_cpu_model (
   input wire logic                clk,
   input wire logic                rst_b,
   input wire ipsc_pkg::ipsc_req_t cpu_req,
   input wire logic                take_en,
   input wire logic [3:0]          dly,
   input wire logic [7:0]          xfer_go,
   input wire logic [7:0]          xfer_sel,
   output ipsc_pkg::ipsc_ack_t     ack
);
   timeunit 1ns / 1ps;
   int cnt;
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ack <= '0;
         cnt <= 0;
      end else begin
         ack.exc_taken <= 8'h00;
         ack.xfer_started <= xfer_go;
         ack.xfer_int_select <= xfer_sel;
         // Hold off after an answer so one request is taken once
         if (cnt < 0)
            cnt <= cnt + 1;
         else if (take_en && cpu_req.valid && cpu_req.source < 5'd8) begin
            if (cnt == int'(dly)) begin
               ack.exc_taken[cpu_req.source[2:0]] <= 1'b1;
               cnt <= -4;
            end else
               cnt <= cnt + 1;
         end else
            cnt <= 0;
      end
   end
endmodule // ipsc_cpu_model

// [bench/test_irq_priority_sense_control.sv]
// Bench for ipsc_core: AHB-Lite register access, detection and forwarding.
// Assumes ipsc_cpu_model on the request side and one bus master.
module test_irq_priority_sense_control;
   timeunit 1ns / 1ps;
   logic        clk = 0, rst_b = 0, hsel = 0, hwrite = 0, imask = 1, take = 0;
   logic        rdy_q, hreadyout, hresp;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rd_q, r;
   logic [7:0]  pins_b = 8'hff, exp_b = 8'hff, xgo = 8'h00, xsel = 8'h00;
   logic [11:0] int_r = 12'h000;
   logic [2:0]  mlvl = 3'h0;
   logic [3:0]  dly = 4'h0;
   int          n_fail = 0, checks_done = 0, i, m;
   ipsc_pkg::ipsc_req_t cpu_req;
   ipsc_pkg::ipsc_ack_t ack;
   always #10 clk = ~clk;
   always @(posedge clk) begin
      rd_q <= hrdata;
      rdy_q <= hreadyout;
   end
   ipsc_core dut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .external_request_pins_b(pins_b),
      .expansion_request_inputs_b(exp_b), .internal_requests(int_r), .cpu_mask_level(mlvl),
      .cpu_int_mask(imask), .ack(ack), .cpu_req(cpu_req));
   ipsc_cpu_model cpu (.clk(clk), .rst_b(rst_b), .cpu_req(cpu_req), .take_en(take),
      .dly(dly), .xfer_go(xgo), .xfer_sel(xsel), .ack(ack));
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wait_rdy;
      int k;
      k = 0;
      do begin
         cyc(1);
         k++;
      end while (rdy_q !== 1'b1 && k < 20);
      chk("hready", {31'h0, rdy_q}, 32'h1);
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      wait_rdy;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy;
      r = rd_q;
      chk("hresp", {31'h0, hresp}, 32'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 32'h0);
      chk(nm, r, e);
   endtask
   task automatic clr;
      bus(1'b0, ipsc_pkg::OFS_FLAGS, 32'h0);
      bus(1'b1, ipsc_pkg::OFS_FLAGS, 32'h0);
   endtask
   task automatic req(input logic v, input logic [4:0] s, input logic [2:0] l);
      cyc(4);
      chk("cpu_req", v ? {23'h0, cpu_req} : {31'h0, cpu_req.valid}, {23'h0, v, s, l});
   endtask
   task automatic xf(input logic [7:0] s);
      xsel <= s;
      xgo <= 8'h20;
      cyc(1);
      xgo <= 8'h00;
      cyc(2);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #200000;
      n_fail++;
      end_of_test;
   end
   initial begin
      cyc(6);
      rst_b <= 1'b1;
      cyc(1);
      for (i = 0; i < 12; i++)
         rd(8'(4 * i), i < 9 ? 32'h77 : 32'h0, "reset");
      for (i = 0; i < 9; i++) begin
         bus(1'b1, 8'(4 * i), 32'hff);
         rd(8'(4 * i), 32'h77, "prio_ff");
         bus(1'b1, 8'(4 * i), 32'ha5);
         rd(8'(4 * i), i == 3 ? 32'h27 : 32'h25, "prio_a5");
      end
      bus(1'b1, 8'h3c, 32'hffffffff);
      rd(8'h3c, 32'h0, "unmapped");
      bus(1'b1, ipsc_pkg::OFS_CONTROL, 32'h2);
      rd(ipsc_pkg::OFS_CONTROL, 32'h2, "mode");
      bus(1'b1, ipsc_pkg::OFS_PRIO_A, 32'h35);
      bus(1'b1, ipsc_pkg::OFS_ENABLE, 32'hff);
      pins_b <= 8'hfc;
      req(1'b1, 5'd1, 3'h5);
      mlvl <= 3'h5;
      req(1'b0, 5'd0, 3'h0);
      mlvl <= 3'h4;
      req(1'b1, 5'd1, 3'h5);
      bus(1'b1, ipsc_pkg::OFS_PRIO_A, 32'h55);
      req(1'b1, 5'd0, 3'h5);
      bus(1'b1, ipsc_pkg::OFS_ENABLE, 32'h02);
      req(1'b1, 5'd1, 3'h5);
      bus(1'b1, ipsc_pkg::OFS_ENABLE, 32'h00);
      req(1'b0, 5'd0, 3'h0);
      pins_b <= 8'hff;
      rd(ipsc_pkg::OFS_FLAGS, 32'h3, "flags_set");
      bus(1'b1, ipsc_pkg::OFS_FLAGS, 32'hff);
      rd(ipsc_pkg::OFS_FLAGS, 32'h3, "write_one");
      bus(1'b1, ipsc_pkg::OFS_FLAGS, 32'hff);
      bus(1'b1, ipsc_pkg::OFS_FLAGS, 32'h00);
      rd(ipsc_pkg::OFS_FLAGS, 32'h3, "no_read");
      bus(1'b1, ipsc_pkg::OFS_FLAGS, 32'hfe);
      rd(ipsc_pkg::OFS_FLAGS, 32'h2, "read_clear");
      clr;
      for (m = 1; m < 4; m++) begin
         bus(1'b1, ipsc_pkg::OFS_SENSE, 32'(m) << 4);
         pins_b <= 8'hfb;
         cyc(3);
         rd(ipsc_pkg::OFS_FLAGS, m != 2 ? 32'h4 : 32'h0, "fall");
         clr;
         pins_b <= 8'hff;
         cyc(3);
         rd(ipsc_pkg::OFS_FLAGS, m > 1 ? 32'h4 : 32'h0, "rise");
         clr;
      end
      bus(1'b1, ipsc_pkg::OFS_SENSE, 32'h440);
      bus(1'b1, ipsc_pkg::OFS_PRIO_B, 32'h66);
      bus(1'b1, ipsc_pkg::OFS_ENABLE, 32'h18);
      take <= 1'b1;
      pins_b <= 8'hf7;
      cyc(2);
      pins_b <= 8'hff;
      cyc(16);
      rd(ipsc_pkg::OFS_FLAGS, 32'h0, "edge_exc");
      dly <= 4'h3;
      pins_b <= 8'hef;
      cyc(16);
      rd(ipsc_pkg::OFS_FLAGS, 32'h10, "low_exc");
      pins_b <= 8'hff;
      cyc(16);
      rd(ipsc_pkg::OFS_FLAGS, 32'h0, "high_exc");
      take <= 1'b0;
      pins_b <= 8'hdf;
      cyc(2);
      pins_b <= 8'hff;
      xf(8'hff);
      rd(ipsc_pkg::OFS_FLAGS, 32'h20, "xfer_keep");
      xf(8'h00);
      rd(ipsc_pkg::OFS_FLAGS, 32'h0, "xfer_clear");
      bus(1'b1, ipsc_pkg::OFS_ENABLE, 32'h00);
      bus(1'b1, ipsc_pkg::OFS_PRIO_D, 32'h50);
      bus(1'b1, ipsc_pkg::OFS_PRIO_M, 32'h60);
      int_r <= 12'h002;
      req(1'b1, 5'd9, 3'h5);
      exp_b <= 8'hfe;
      req(1'b1, 5'd20, 3'h6);
      rd(ipsc_pkg::OFS_STATUS, {23'h0, 1'b1, 5'd20, 3'h6}, "status");
      bus(1'b1, ipsc_pkg::OFS_CONTROL, 32'h0);
      req(1'b0, 5'd0, 3'h0);
      imask <= 1'b0;
      mlvl <= 3'h7;
      req(1'b1, 5'd20, 3'h6);
      bus(1'b1, ipsc_pkg::OFS_CONTROL, 32'h1);
      req(1'b0, 5'd0, 3'h0);
      end_of_test;
   end
endmodule // test_irq_priority_sense_control
bind ipsc_core ipsc_core_assertions chk_i (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .expansion_request_inputs_b(expansion_request_inputs_b),
   .internal_requests(internal_requests), .cpu_mask_level(cpu_mask_level),
   .cpu_int_mask(cpu_int_mask), .cpu_req(cpu_req));

// [logic/ipsc_core.sv]
// Interrupt priority and sense control: pin detection, flags, priority select.
// Assumes a single-slave AHB-Lite bus; sources outside the pins arrive as levels.
//
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
module ipsc_core (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic             hsel,
   input  wire logic [31:0]      haddr,
   input  wire logic [1:0]       htrans,
   input  wire logic             hwrite,
   input  wire logic [2:0]       hsize,
   input  wire logic [31:0]      hwdata,
   input  wire logic             hready,
   output logic      [31:0]      hrdata,
   output logic                  hreadyout,
   output logic                  hresp,
   input  wire logic [7:0]       external_request_pins_b,
   input  wire logic [7:0]       expansion_request_inputs_b,
   input  wire logic [11:0]      internal_requests,
   input  wire logic [2:0]       cpu_mask_level,
   input  wire logic             cpu_int_mask,
   input  wire ipsc_pkg::ipsc_ack_t ack,
   output ipsc_pkg::ipsc_req_t   cpu_req
);
   // Internal request bits: 0 transfer end, 1 watchdog, 2-4 timer ch0..2,
   // 5 DMA, 6-8 serial ch0..2 (grouped per field), 9-11 unused
   logic [7:0]  prio [ipsc_pkg::NUM_PRIO];
   logic [7:0]  pin_request_enable;
   logic [15:0] pin_sense_select;
   logic [7:0]  pin_request_flags;
   logic [7:0]  pin_prev;
   logic [7:0]  flag_seen_one;
   logic [1:0]  control_mode;
   logic        ph_write;
   logic [7:0]  ph_addr;

   // Address phase capture
   wire         addr_take = hsel && hready && htrans[1];
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ph_write <= 1'b0;
         ph_addr  <= 8'h00;
      end else if (hready) begin
         ph_write <= addr_take && hwrite;
         ph_addr  <= haddr[7:0];
      end
   end

   wire       wr_en     = ph_write;
   wire [7:0] wdata     = hwdata[7:0];
   wire       wr_enable = wr_en && (ph_addr == ipsc_pkg::OFS_ENABLE);
   wire       wr_sense  = wr_en && (ph_addr == ipsc_pkg::OFS_SENSE);
   wire       wr_flags  = wr_en && (ph_addr == ipsc_pkg::OFS_FLAGS);
   wire       wr_ctrl   = wr_en && (ph_addr == ipsc_pkg::OFS_CONTROL);
   wire       rd_flags  = addr_take && !hwrite && (haddr[7:0] == ipsc_pkg::OFS_FLAGS);

   // Priority registers, one per word at consecutive offsets
   genvar g;
   generate
      for (g = 0; g < ipsc_pkg::NUM_PRIO; g++) begin : g_prio
         localparam logic [7:0] OFS = 8'(4 * g);
         wire wr_this = wr_en && (ph_addr == OFS);
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               prio[g] <= ipsc_pkg::PRIO_RESET;
            end else if (wr_this) begin
               if (g == ipsc_pkg::PRIO_D_IDX) begin
                  prio[g] <= {1'b0, wdata[6:4], ipsc_pkg::PRIO_D_RSVD[3:0]};
               end else begin
                  prio[g] <= wdata & ipsc_pkg::PRIO_KEEP;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_request_enable <= ipsc_pkg::ENABLE_RESET;
         pin_sense_select   <= ipsc_pkg::SENSE_RESET;
         control_mode       <= ipsc_pkg::MODE_RESET;
      end else begin
         if (wr_enable) begin
            pin_request_enable <= wdata;
         end
         if (wr_sense) begin
            pin_sense_select <= hwdata[15:0];
         end
         if (wr_ctrl) begin
            control_mode <= hwdata[1:0];
         end
      end
   end

   // Pin detection and flags, per pin
   logic [7:0] next_flags;
   logic [7:0] next_seen;
   generate
      for (g = 0; g < 8; g++) begin : g_pin
         wire [1:0] mode   = pin_sense_select[2*g+1:2*g];
         wire       pin    = external_request_pins_b[g];
         wire       fall   = pin_prev[g] && !pin;
         wire       rise   = !pin_prev[g] && pin;
         wire       set_it = (mode == ipsc_pkg::IPSC_SENSE_LOW  && !pin) ||
                             (mode == ipsc_pkg::IPSC_SENSE_FALL && fall) ||
                             (mode == ipsc_pkg::IPSC_SENSE_RISE && rise) ||
                             (mode == ipsc_pkg::IPSC_SENSE_BOTH && (fall || rise));
         wire       sw_clr = wr_flags && !wdata[g] && flag_seen_one[g];
         wire       hw_clr = ack.exc_taken[g] && ((mode == ipsc_pkg::IPSC_SENSE_LOW) ? pin
                             : 1'b1);
         wire       tx_clr = ack.xfer_started[g] && !ack.xfer_int_select[g];
         // Setting wins over any clearing in the same cycle
         assign next_flags[g] = set_it || (pin_request_flags[g] && !(sw_clr || hw_clr || tx_clr));
         assign next_seen[g]  = (rd_flags && pin_request_flags[g]) ||
                                (flag_seen_one[g] && !wr_flags && pin_request_flags[g]);
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_request_flags <= ipsc_pkg::FLAGS_RESET;
         flag_seen_one     <= 8'h00;
         pin_prev          <= 8'hff;
      end else begin
         pin_request_flags <= next_flags;
         flag_seen_one     <= next_seen;
         pin_prev          <= external_request_pins_b;
      end
   end

   // Source table in vector order with levels
   logic [ipsc_pkg::NUM_SRC-1:0] src_req;
   logic [2:0]                   src_lvl [ipsc_pkg::NUM_SRC];
   wire  [7:0] pin_active = pin_request_flags & pin_request_enable;
   wire  [7:0] exp_active = ~expansion_request_inputs_b;
   generate
      for (g = 0; g < 8; g++) begin : g_src_pin
         localparam int R = (g == 0) ? 0 : (g == 1) ? 0 : (g < 6) ? 1 : 2;
         localparam bit UP = (g == 0) || (g == 2) || (g == 3) || (g == 6) || (g == 7);
         assign src_req[g] = pin_active[g];
         assign src_lvl[g] = UP ? prio[R][6:4] : prio[R][2:0];
      end
      for (g = 0; g < 8; g++) begin : g_src_exp
         assign src_req[20+g] = exp_active[g];
         assign src_lvl[20+g] = (g < 4) ? prio[8][6:4] : prio[8][2:0];
      end
      for (g = 28; g < 32; g++) begin : g_src_none
         assign src_req[g] = 1'b0;
         assign src_lvl[g] = 3'h0;
      end
   endgenerate
   assign src_req[8]  = internal_requests[0];
   assign src_lvl[8]  = prio[2][2:0];
   assign src_req[9]  = internal_requests[1];
   assign src_lvl[9]  = prio[3][6:4];
   assign src_req[10] = internal_requests[2];
   assign src_lvl[10] = prio[4][6:4];
   assign src_req[11] = internal_requests[3];
   assign src_lvl[11] = prio[4][2:0];
   assign src_req[12] = internal_requests[4];
   assign src_lvl[12] = prio[5][6:4];
   assign src_req[13] = internal_requests[5];
   assign src_lvl[13] = prio[6][6:4];
   assign src_req[14] = internal_requests[6];
   assign src_lvl[14] = prio[6][2:0];
   assign src_req[15] = internal_requests[7];
   assign src_lvl[15] = prio[7][6:4];
   assign src_req[16] = internal_requests[8];
   assign src_lvl[16] = prio[7][2:0];
   assign src_req[17] = 1'b0;
   assign src_lvl[17] = 3'h0;
   assign src_req[18] = 1'b0;
   assign src_lvl[18] = 3'h0;
   assign src_req[19] = 1'b0;
   assign src_lvl[19] = 3'h0;

   // Highest level wins; strict compare keeps the lower index on ties
   logic       best_valid;
   logic [4:0] best_src;
   logic [2:0] best_lvl;
   always_comb begin
      best_valid = 1'b0;
      best_src   = 5'h00;
      best_lvl   = 3'h0;
      for (int i = 0; i < ipsc_pkg::NUM_SRC; i++) begin
         if (src_req[i] && (!best_valid || src_lvl[i] > best_lvl)) begin
            best_valid = 1'b1;
            best_src   = 5'(i);
            best_lvl   = src_lvl[i];
         end
      end
   end

   wire mode0   = control_mode == ipsc_pkg::IPSC_MODE_0;
   wire mode2   = control_mode == ipsc_pkg::IPSC_MODE_2;
   wire fwd_ok  = (mode0 && !cpu_int_mask) ||
                  (mode2 && best_lvl > cpu_mask_level);
   ipsc_pkg::ipsc_req_t next_req;
   assign next_req = '{valid: best_valid && fwd_ok, source: best_src, level: best_lvl};

   // Read mux
   logic [31:0] next_rdata;
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (addr_take && !hwrite) begin
         if (haddr[7:0] <= ipsc_pkg::OFS_PRIO_M && haddr[1:0] == 2'h0) begin
            next_rdata = {24'h000000, prio[haddr[5:2]]};
         end else if (haddr[7:0] == ipsc_pkg::OFS_ENABLE) begin
            next_rdata = {24'h000000, pin_request_enable};
         end else if (haddr[7:0] == ipsc_pkg::OFS_SENSE) begin
            next_rdata = {16'h0000, pin_sense_select};
         end else if (haddr[7:0] == ipsc_pkg::OFS_FLAGS) begin
            next_rdata = {24'h000000, pin_request_flags};
         end else if (haddr[7:0] == ipsc_pkg::OFS_CONTROL) begin
            next_rdata = {30'h0, control_mode};
         end else if (haddr[7:0] == ipsc_pkg::OFS_STATUS) begin
            next_rdata = {23'h0, cpu_req.valid, cpu_req.source, cpu_req.level};
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         cpu_req   <= '0;
      end else begin
         if (hready) begin
            hrdata <= next_rdata;
         end
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         cpu_req   <= next_req;
      end
   end
endmodule // ipsc_core

// [logic/ipsc_pkg.sv]
// Package for the interrupt priority and sense control block: offsets, resets, types.
// Assumes a 32-bit AHB-Lite register bus with one register per aligned word.
//
// Functional notes
// - Nine 8-bit priority registers, two 3-bit fields at bits 6-4 and 2-0.
// - Priority field value 0 is lowest level, 7 is highest.
// - Priority registers reset to 0x77, kept through software standby.
// - Bits 7 and 3 of every priority register read as 0.
// - Fields map to pins 0-7, transfer controller and expansion inputs.
// - Fields map to watchdog, timer channels, DMA and serial channels.
// - Lower field of priority register D is reserved, unwritable, reads ones.
// - The highest priority pending request becomes the candidate.
// - In mode 2, candidate is forwarded only when level is above the CPU mask level.
// - Enable register bit n enables pin request n; resets to 0x00.
// - Two sense bits per pin at bits 2n+1 and 2n; pair resets to 0x0000.
// - Sense 00 low level, 01 falling, 10 rising, 11 both edges.
// - Flag n sets on low level or on the selected edge.
// - A flag clears by reading it as 1 then writing 0.
// - Writing 1 to a flag has no effect.
// - Low-level mode: exception handling clears flag when pin is high.
// - Edge modes: exception handling for request n clears flag n.
// - Transfer activation with select bit 0 clears flag n.
// - Flag register resets to 0x00, kept through software standby.
// - Mode 0 masks with the CPU interrupt bit; mode 2 uses mask level.
// - Flags set regardless of enable bits; enables gate forwarding only.
// - Equal priority goes to the lower vector number.
// - Each expansion input requests while driven low.
package ipsc_pkg;
   localparam logic [7:0] OFS_PRIO_A   = 8'h00;
   localparam logic [7:0] OFS_PRIO_B   = 8'h04;
   localparam logic [7:0] OFS_PRIO_C   = 8'h08;
   localparam logic [7:0] OFS_PRIO_D   = 8'h0c;
   localparam logic [7:0] OFS_PRIO_F   = 8'h10;
   localparam logic [7:0] OFS_PRIO_G   = 8'h14;
   localparam logic [7:0] OFS_PRIO_J   = 8'h18;
   localparam logic [7:0] OFS_PRIO_K   = 8'h1c;
   localparam logic [7:0] OFS_PRIO_M   = 8'h20;
   localparam logic [7:0] OFS_ENABLE   = 8'h24;
   localparam logic [7:0] OFS_SENSE    = 8'h28;
   localparam logic [7:0] OFS_FLAGS    = 8'h2c;
   localparam logic [7:0] OFS_CONTROL  = 8'h30;
   localparam logic [7:0] OFS_STATUS   = 8'h34;
   localparam int         NUM_PRIO     = 9;
   localparam int         NUM_SRC      = 32;
   localparam logic [7:0] PRIO_RESET   = 8'h77;
   localparam logic [7:0] PRIO_KEEP    = 8'h77;
   localparam logic [7:0] PRIO_D_RSVD  = 8'h07;
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   localparam logic [15:0] SENSE_RESET = 16'h0000;
   localparam logic [7:0] FLAGS_RESET  = 8'h00;
   localparam logic [1:0] MODE_RESET   = 2'h0;
   localparam int         PRIO_D_IDX   = 3;

   typedef enum logic [1:0] {
      IPSC_SENSE_LOW  = 2'h0,
      IPSC_SENSE_FALL = 2'h1,
      IPSC_SENSE_RISE = 2'h2,
      IPSC_SENSE_BOTH = 2'h3
   } ipsc_sense_t;

   typedef enum logic [1:0] {
      IPSC_MODE_0   = 2'h0,
      IPSC_MODE_BAD = 2'h1,
      IPSC_MODE_2   = 2'h2,
      IPSC_MODE_BAD2 = 2'h3
   } ipsc_mode_t;

   // Request to the CPU: valid, source index (lower index = lower vector), level
   typedef struct packed {
      logic       valid;
      logic [4:0] source;
      logic [2:0] level;
   } ipsc_req_t;

   // Acknowledge from the CPU and transfer controller for pin requests
   typedef struct packed {
      logic [7:0] exc_taken;
      logic [7:0] xfer_started;
      logic [7:0] xfer_int_select;
   } ipsc_ack_t;
endpackage : ipsc_pkg
